// ===== ilk_diag.sv
`timescale 1ns/100ps
// Behaviour
// - internal error drops both safety outputs at once
// - error clears after cause gone and guard recycled
// - warning pulls diag low, outputs stay on
// - warning clears itself when cause goes
// - warning held thirty minutes becomes shutdown fault
// - closed unlocked: yellow flashes, green on, diag high
// - closed locked: yellow steady, outputs and diag high
// - warnings flash red one to four pulses
// - immediate faults: five, six pulses, or steady
// - channel A warning on test fail or foreign voltage
// - channel B warning on test fail or foreign voltage
// - cross-wire warning on short or both faulty
// - overtemperature warning above temperature limit
// - unlock-disabling variant: unlock drops outputs, relock restores
// - open-disabling variant: opening drops outputs, unlocking does not
module ilk_diag
	import ilk_pkg::*;
#(
	parameter longint ESCALATE = WARN_ESCALATE_CYC,
	parameter int BLINK = int'(BLINK_CYC),
	parameter int PULSE = int'(PULSE_CYC),
	parameter int PAUSE = int'(PAUSE_CYC)
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// strapped variant options
	input wire logic power_to_lock,
	input wire logic open_disabling,
	// controller and upstream chain
	input wire logic solenoid_cmd,
	input wire logic safety_in_a,
	input wire logic safety_in_b,
	// mechanics and sensors
	input wire logic guard_closed,
	input wire logic lock_engaged,
	// monitor results
	input wire logic test_fail_a,
	input wire logic test_fail_b,
	input wire logic out_volt_a,
	input wire logic out_volt_b,
	input wire logic lines_shorted,
	input wire logic over_temp,
	input wire logic actuator_fault,
	input wire logic handle_fault,
	input wire logic internal_defect,
	// outputs
	output logic safety_out_a,
	output logic safety_out_b,
	output logic diag_out,
	output logic lock_request,
	output logic led_green,
	output logic led_yellow,
	output logic led_red
);
	logic fault_latched;
	logic [2:0] fault_code;
	logic [63:0] warn_timer;
	logic escalated;
	logic guard_prev;
	logic open_seen;
	logic [31:0] blink_cnt;
	logic blink;
	logic next_out;

	// lock request from command polarity of the variant
	assign lock_request = power_to_lock ? solenoid_cmd : !solenoid_cmd;

	// warning sources; an output reading voltage while off is foreign drive
	wire warn_a = test_fail_a || (out_volt_a && !safety_out_a);
	wire warn_b = test_fail_b || (out_volt_b && !safety_out_b);
	wire warn_x = lines_shorted || (warn_a && warn_b);
	wire warn_t = over_temp;
	wire warn_any = warn_a || warn_b || warn_x || warn_t;
	// full code width; a bare wire here would keep only the low bit
	wire [2:0] warn_code = warn_x ? CODE_CROSS : warn_a ? CODE_OUT_A :
		warn_b ? CODE_OUT_B : warn_t ? CODE_TEMP : CODE_NONE;
	wire immediate = internal_defect || actuator_fault || handle_fault;
	wire [2:0] imm_code = internal_defect ? CODE_STEADY :
		actuator_fault ? CODE_ACT : CODE_HANDLE;
	wire escalate_now = warn_any && (warn_timer >= ESCALATE - 64'h1);
	wire fault_set = immediate || escalate_now;
	wire guard_cycled = open_seen && guard_closed;
	wire chain_ok = safety_in_a && safety_in_b;

	// escalation timer; any drop of the warning restarts it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) warn_timer <= 64'h0;
		else if (ce) warn_timer <= warn_any ? warn_timer + 64'h1 : 64'h0;
	end

	// fault latch: set wins; clears only after cause gone and guard recycled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_latched <= 1'b0;
			fault_code <= CODE_NONE;
			escalated <= 1'b0;
			open_seen <= 1'b0;
			guard_prev <= 1'b0;
		end else if (ce) begin
			guard_prev <= guard_closed;
			if (fault_set) begin
				fault_latched <= 1'b1;
				escalated <= escalate_now && !immediate;
				fault_code <= immediate ? imm_code : warn_code;
				open_seen <= 1'b0;
			end else if (fault_latched) begin
				if (guard_prev && !guard_closed) open_seen <= 1'b1;
				if (guard_cycled && !warn_any) begin
					fault_latched <= 1'b0;
					escalated <= 1'b0;
					fault_code <= CODE_NONE;
					open_seen <= 1'b0;
				end
			end
		end
	end

	// enable path by variant
	always_comb begin
		next_out = 1'b0;
		if (guard_closed && chain_ok && !fault_latched && !immediate) begin
			if (open_disabling) next_out = 1'b1;
			else next_out = lock_engaged;
		end
	end

	// registered safety outputs and diagnostic line
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			safety_out_a <= 1'b0;
			safety_out_b <= 1'b0;
			diag_out <= 1'b0;
		end else if (ce) begin
			safety_out_a <= next_out && !fault_set;
			safety_out_b <= next_out && !fault_set;
			// diag high while closed, clean and either locked or not asked
			// to lock; a lock wish that is not met reads as not lockable
			diag_out <= guard_closed && !fault_latched && !fault_set &&
				!warn_any && (lock_engaged || !lock_request);
		end
	end

	// 1 Hz blink base for yellow and green
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			blink_cnt <= 32'h0000_0000;
			blink <= 1'b0;
		end else if (ce) begin
			if (blink_cnt >= 32'(BLINK - 1)) begin
				blink_cnt <= 32'h0000_0000;
				blink <= !blink;
			end else blink_cnt <= blink_cnt + 32'h0000_0001;
		end
	end

	// lamps: green flashes without upstream chain, yellow shows lock state
	assign led_green = chain_ok ? 1'b1 : blink;
	assign led_yellow = !guard_closed || fault_latched ? 1'b0 :
		lock_engaged ? 1'b1 : blink;
	wire [2:0] red_code = fault_latched ? fault_code :
		warn_any ? warn_code : CODE_NONE;

	ilk_flash #(.PULSE(PULSE), .PAUSE(PAUSE)) u_flash (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.code(red_code),
		.led(led_red)
	);

	imm_shutdown_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && immediate) |=> !safety_out_a && !safety_out_b)
		else $error("outputs on after immediate fault");
	fault_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && fault_latched && !open_seen && !fault_set) |=> fault_latched)
		else $error("fault cleared without guard cycle");
	warn_diag_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && warn_any && !fault_latched && !fault_set && next_out)
		|=> !diag_out && safety_out_a)
		else $error("warning signalling wrong");
	warn_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && !warn_any) |=> warn_timer == 64'h0)
		else $error("warning timer not cleared");
	escalate_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && escalate_now) |=> fault_latched && !safety_out_a)
		else $error("warning not escalated");
	lock_pol_a: assert property (@(posedge clk) disable iff (!nrst)
		lock_request == (solenoid_cmd ~^ power_to_lock))
		else $error("lock polarity wrong");
	unlock_drop_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && !open_disabling && !lock_engaged) |=> !safety_out_b)
		else $error("outputs on while unlocked");
	open_keep_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && open_disabling && guard_closed && chain_ok && !fault_latched
		&& !fault_set && !immediate) |=> safety_out_a)
		else $error("outputs off while closed");
	yellow_lock_a: assert property (@(posedge clk) disable iff (!nrst)
		(guard_closed && lock_engaged && !fault_latched) |-> led_yellow)
		else $error("yellow not steady when locked");
endmodule : ilk_diag

// ===== ilk_pkg.sv
package ilk_pkg;
	// system tick rate and derived timing
	localparam longint CLK_HZ = 20_000_000;
	localparam longint WARN_ESCALATE_MIN = 30;
	localparam longint WARN_ESCALATE_CYC = WARN_ESCALATE_MIN * 60 * CLK_HZ;
	// indicator timing in milliseconds
	localparam longint BLINK_MS = 500;
	localparam longint BLINK_CYC = BLINK_MS * CLK_HZ / 1000;
	localparam longint PULSE_MS = 250;
	localparam longint PULSE_CYC = PULSE_MS * CLK_HZ / 1000;
	localparam longint PAUSE_MS = 2000;
	localparam longint PAUSE_CYC = PAUSE_MS * CLK_HZ / 1000;
	// flash code pulse counts; 7 means steady
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_OUT_A = 3'h1;
	localparam logic [2:0] CODE_OUT_B = 3'h2;
	localparam logic [2:0] CODE_CROSS = 3'h3;
	localparam logic [2:0] CODE_TEMP = 3'h4;
	localparam logic [2:0] CODE_ACT = 3'h5;
	localparam logic [2:0] CODE_HANDLE = 3'h6;
	localparam logic [2:0] CODE_STEADY = 3'h7;
	// burst generator states
	typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_PAUSE} ilk_flash_type;
endpackage : ilk_pkg

// ===== ilk_flash.sv
`timescale 1ns/100ps
module ilk_flash
	import ilk_pkg::*;
#(
	parameter int PULSE = int'(PULSE_CYC),
	parameter int PAUSE = int'(PAUSE_CYC)
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// code in, lamp out
	input wire logic [2:0] code,
	output logic led
);
	ilk_flash_type state;
	logic [31:0] timer;
	logic [2:0] count;
	wire timer_done = (timer == 32'h0000_0000);

	// bursts of n pulses, then a long dark pause before repeating
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= FL_IDLE;
			timer <= 32'h0000_0000;
			count <= 3'h0;
			led <= 1'b0;
		end else if (ce) begin
			case (state)
				FL_IDLE: begin
					led <= (code == CODE_STEADY);
					if (code != CODE_NONE && code != CODE_STEADY) begin
						state <= FL_ON;
						count <= code;
						timer <= 32'(PULSE - 1);
						led <= 1'b1;
					end
				end
				FL_ON: begin
					if (timer_done) begin
						state <= FL_OFF;
						led <= 1'b0;
						count <= count - 3'h1;
						timer <= 32'(PULSE - 1);
					end else timer <= timer - 32'h0000_0001;
				end
				FL_OFF: begin
					if (!timer_done) timer <= timer - 32'h0000_0001;
					else if (count != 3'h0) begin
						state <= FL_ON;
						led <= 1'b1;
						timer <= 32'(PULSE - 1);
					end else begin
						state <= FL_PAUSE;
						timer <= 32'(PAUSE - 1);
					end
				end
				FL_PAUSE: begin
					if (timer_done) state <= FL_IDLE;
					else timer <= timer - 32'h0000_0001;
				end
				default: state <= FL_IDLE;
			endcase
		end
	end

	pause_long_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && state == FL_OFF && timer_done && count == 3'h0)
		|=> !led [*8])
		else $error("flash pause too short");
endmodule : ilk_flash

// ===== ilk_plc.sv
`timescale 1ns/100ps
module ilk_plc (
	// clock
	input wire logic clk,
	// lock wish and variant strap
	input wire logic want_lock,
	input wire logic power_to_lock,
	// command to the interlock
	output logic solenoid_cmd = 1'b0
);
	// polarity follows the strap; moved off the sampling edge
	always @(negedge clk) begin
		solenoid_cmd <= power_to_lock ? want_lock : !want_lock;
	end
endmodule : ilk_plc

// ===== interlock_diag_fault_signalling_tb_top.sv
`timescale 1ns/100ps
module interlock_diag_fault_signalling_tb_top;
	import ilk_pkg::*;
	localparam int ESC = 100;
	logic clk = 0, nrst = 0, ce = 1, power_to_lock = 0, open_disabling = 0;
	logic want_lock = 0, solenoid_cmd, safety_in_a = 1, safety_in_b = 1;
	logic guard_closed = 0, lock_engaged = 0;
	logic [8:0] cause = '0;
	logic safety_out_a, safety_out_b, diag_out, lock_request;
	logic led_green, led_yellow, led_red;
	logic [8:0] wm [7] = '{9'h001, 9'h004, 9'h002, 9'h008, 9'h010, 9'h003,
		9'h020};
	int wn [7] = '{1, 1, 2, 2, 3, 3, 4};
	int n_mismatch = 0, n_tests = 0, n, k;
	// short counts keep the run brief
	ilk_diag #(.ESCALATE(ESC), .BLINK(4), .PULSE(2), .PAUSE(20)) DUT (
		.clk, .nrst, .ce, .power_to_lock, .open_disabling, .solenoid_cmd,
		.safety_in_a, .safety_in_b, .guard_closed, .lock_engaged,
		.test_fail_a(cause[0]), .test_fail_b(cause[1]),
		.out_volt_a(cause[2]), .out_volt_b(cause[3]),
		.lines_shorted(cause[4]), .over_temp(cause[5]),
		.actuator_fault(cause[6]), .handle_fault(cause[7]),
		.internal_defect(cause[8]), .safety_out_a, .safety_out_b,
		.diag_out, .lock_request, .led_green, .led_yellow, .led_red);
	ilk_plc plc (.clk, .want_lock, .power_to_lock, .solenoid_cmd);
	// 50 ns clock
	initial forever #25 clk = ~clk;
	task automatic step(int c);
		repeat (c) @(negedge clk);
	endtask : step
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	// counts red rises; a lamp already lit at the start counts once
	task automatic reds(int c);
		logic p;
		p = 1'b0;
		n = 0;
		repeat (c) begin
			@(negedge clk);
			if (led_red && !p) n++;
			p = led_red;
		end
	endtask : reds
	function automatic logic exp_out(logic od, logic cl, logic lk, logic ch);
		return cl & ch & (od | lk);
	endfunction : exp_out
	// guard opened and closed again, leaving it closed
	task automatic recycle();
		guard_closed = 0;
		step(3);
		guard_closed = 1;
		step(3);
	endtask : recycle
	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	// watchdog well past the expected run of about 1000 cycles
	initial begin
		repeat (3000) @(negedge clk);
		n_mismatch++;
		stop_test();
	end
	// main sequence
	initial begin
		void'($urandom(52929));
		step(8);
		nrst = 1;
		step(2);
		chk("rst out", {safety_out_a, safety_out_b, diag_out}, 0);
		guard_closed = 1;
		for (k = 0; k < 4; k++) begin
			{power_to_lock, open_disabling} = k[1:0];
			want_lock = 1;
			lock_engaged = 1;
			step(3);
			chk("req lock", lock_request, 1);
			chk("locked", {safety_out_a, safety_out_b, diag_out}, 7);
			chk("lock led", {led_green, led_yellow, led_red}, 6);
			want_lock = 0;
			lock_engaged = 0;
			step(3);
			chk("req unl", lock_request, 0);
			chk("unl out", safety_out_a, k[0]);
			chk("unl led", {led_green, led_red, diag_out}, 5);
			n = 0;
			repeat (12) begin
				step(1);
				n += led_yellow;
			end
			chk("yel blink", n inside {[2:10]}, 1);
		end
		open_disabling = 0;
		lock_engaged = 1;
		step(3);
		chk("relock", safety_out_b, 1);
		// clock enable low freezes the outputs
		ce = 0;
		guard_closed = 0;
		step(3);
		chk("ce hold", safety_out_a, 1);
		guard_closed = 1;
		ce = 1;
		step(3);
		// warnings, one cause at a time except both test fails together, flasher idle in between
		for (k = 0; k < 7; k++) begin
			// foreign voltage only counts on an output that is off
			guard_closed = !(k inside {1, 3});
			cause = wm[k];
			reds(4 * wn[k] + 8);
			chk("warn code", n[7:0], wn[k][7:0]);
			chk("warn out", {safety_out_a, safety_out_b, diag_out},
				guard_closed ? 8'd6 : 8'd0);
			cause = '0;
			guard_closed = 1;
			step(2);
			chk("warn gone", diag_out, 1);
			step(30);
		end
		cause = 9'h020;
		step(ESC - 10);
		chk("pre esc", safety_out_a, 1);
		step(20);
		chk("esc", {safety_out_a, safety_out_b}, 0);
		cause = '0;
		step(3);
		chk("esc held", safety_out_a, 0);
		recycle();
		chk("esc clr", safety_out_a, 1);
		for (k = 0; k < 3; k++) begin
			// long enough for any burst and pause left over to finish
			step(40);
			cause = 9'h040 << k;
			reds(30);
			chk("imm code", n[7:0], k == 2 ? 8'd1 : 8'(5 + k));
			chk("imm out", {safety_out_a, safety_out_b, diag_out}, 0);
			if (k == 2) chk("steady", led_red, 1);
			cause = '0;
			step(3);
			chk("imm held", safety_out_b, 0);
			recycle();
			chk("imm clr", safety_out_b, 1);
		end
		// random mechanics and chain levels
		repeat (40) begin
			open_disabling = $urandom;
			guard_closed = $urandom;
			lock_engaged = $urandom;
			safety_in_a = ($urandom % 4) != 0;
			safety_in_b = ($urandom % 4) != 0;
			step(3);
			chk("rnd out", safety_out_a, exp_out(open_disabling, guard_closed,
				lock_engaged, safety_in_a & safety_in_b));
			if (safety_in_a && safety_in_b) chk("rnd grn", led_green, 1);
		end
		stop_test();
	end
endmodule : interlock_diag_fault_signalling_tb_top
